// [src/btcc_pkg.sv]
`default_nettype none
// ****************************************************************
// shared constants for the bridge time-out and chip-control bank
// ****************************************************************
package btcc_pkg;
    // dword addresses of the two configuration dwords
    localparam logic [7:0] BRIDGE_DWORD_ADDR = 8'h3C;
    localparam logic [7:0] CHIP_DWORD_ADDR = 8'h40;
    // bridge control upper field positions within the dword
    localparam int FBB_EN_BIT = 23;
    localparam int PRI_TMO_SEL_BIT = 24;
    localparam int SEC_TMO_SEL_BIT = 25;
    localparam int TMO_STATUS_BIT = 26;
    localparam int TMO_SERR_EN_BIT = 27;
    // chip control field positions within the dword
    localparam int MW_DISC_CTL_BIT = 1;
    localparam int SEC_PF_DIS_BIT = 4;
    localparam int LIVE_INS_BIT = 5;
    // byte enable lanes that select writable fields
    localparam int BRIDGE_UPPER_LANE = 3;
    localparam int CHIP_CTL_LANE = 0;
    // reset values of every writable field
    localparam logic RST_TMO_SEL = 1'b0;
    localparam logic RST_TMO_STATUS = 1'b0;
    localparam logic RST_TMO_SERR_EN = 1'b0;
    localparam logic RST_MW_DISC_CTL = 1'b0;
    localparam logic RST_SEC_PF_DIS = 1'b0;
    localparam logic RST_LIVE_INS = 1'b0;
    // bits that always read zero in either dword
    localparam logic [31:0] RSVD_MASK = 32'hF0FF_FFCD;
    // master time-out lengths in pci clock cycles
    localparam int unsigned TMO_LONG_CYCLES = 32768;
    localparam int unsigned TMO_SHORT_CYCLES = 1024;
    localparam int TMO_CNT_W = 16;
    // pci command codes of the memory read family
    localparam logic [3:0] CMD_MEM_READ = 4'h6;
    localparam logic [3:0] CMD_MEM_READ_MULT = 4'hC;
    localparam logic [3:0] CMD_MEM_READ_LINE = 4'hE;
    // address bits that mark a 4 kB boundary
    localparam int PAGE_ADDR_W = 10;
endpackage : btcc_pkg
`default_nettype wire

// [src/btcc_top.sv]
`default_nettype none
// How it works
// - fast back-to-back bit reads zero, never generated
// - same time-out discard for secondary initiators
// - discard sets status flag, write one clears
// - report enable and command enable drive serr
// - reserved bits read-only, always read zero
// - only byte-enabled lanes are written
// - disconnect writes on full, 4 kB, cache line
// - prefetch enabled: prefetch, byte enables not forwarded
// - prefetch disabled: one dword, disconnect first
// - live insertion pin masks forwarding enables
module btcc_top #(
    parameter int unsigned TMO_LONG = btcc_pkg::TMO_LONG_CYCLES,   // select bit 0 length
    parameter int unsigned TMO_SHORT = btcc_pkg::TMO_SHORT_CYCLES  // select bit 1 length
) (
    input wire logic MCLK,                         // pci clock
    input wire logic ARST_N,                       // async reset, active low
    input wire logic CFG_WR,                       // config write strobe
    input wire logic CFG_RD,                       // config read strobe
    input wire logic [7:0] CFG_ADDR,               // config dword address
    input wire logic [3:0] PRIMARY_CMD_BYTE_ENABLE_N, // data phase byte enables
    input wire logic [31:0] CFG_WDATA,             // config write data
    output logic [31:0] CFG_RDATA,                 // config read data
    output logic CFG_RVALID,                       // read data valid pulse
    input wire logic CMD_SERR_EN,                  // command register serr enable
    input wire logic CMD_IO_EN,                    // command register io enable
    input wire logic CMD_MEM_EN,                   // command register memory enable
    input wire logic CMD_MASTER_EN,                // command register master enable
    input wire logic [1:0] DT_HEAD,                // completion at queue head, [0] primary
    input wire logic [1:0] DT_REPEAT,              // initiator repeated request
    output logic [1:0] DT_DISCARD,                 // discard pulse per bus
    output logic PRIMARY_SYSTEM_ERROR_N_O,         // serr pin output value
    output logic PRIMARY_SYSTEM_ERROR_N_OE,        // serr pin drive enable
    output logic SEC_FAST_B2B_EN,                  // fast back-to-back issue enable
    input wire logic MW_QUEUE_FULL,                // posted write queue full
    input wire logic [9:0] MW_NEXT_ADDR,           // next dword address bits 11:2
    input wire logic [7:0] CACHE_LINE_DW,          // cache line size in dwords
    output logic MW_DISCONNECT,                    // disconnect current write
    input wire logic [3:0] US_RD_CMD,              // upstream read command
    output logic US_PREFETCH,                      // prefetch this upstream read
    output logic US_FWD_BE,                        // forward requester byte enables
    output logic US_DISC_FIRST,                    // disconnect after first data
    input wire logic GPIO3_IN,                     // live insertion pin
    input wire logic GPIO3_INPUT_ONLY,             // pin configured input only
    output logic IO_EN_EFF,                        // effective io enable
    output logic MEM_EN_EFF,                       // effective memory enable
    output logic MASTER_EN_EFF,                    // effective master enable
    output logic ACCEPT_BLOCK                      // refuse io and memory cycles
);

    // ****************************************************************
    // configuration register file
    // ****************************************************************

    logic [1:0] tmo_sel_r;
    logic tmo_status_r;
    logic tmo_status_nxt;
    logic tmo_serr_en_r;
    logic mw_disc_ctl_r;
    logic sec_pf_dis_r;
    logic live_ins_r;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic rvalid_r;
    wire [1:0] expire;

    // address decode and lane selects
    wire hit_bridge = CFG_ADDR == btcc_pkg::BRIDGE_DWORD_ADDR;
    wire hit_chip = CFG_ADDR == btcc_pkg::CHIP_DWORD_ADDR;
    wire wr_upper = CFG_WR && hit_bridge
        && !PRIMARY_CMD_BYTE_ENABLE_N[btcc_pkg::BRIDGE_UPPER_LANE];
    wire wr_chip = CFG_WR && hit_chip
        && !PRIMARY_CMD_BYTE_ENABLE_N[btcc_pkg::CHIP_CTL_LANE];
    wire status_clr = wr_upper && CFG_WDATA[btcc_pkg::TMO_STATUS_BIT];

    // status flag: a discard in the clearing cycle wins
    assign tmo_status_nxt = (|expire) || (tmo_status_r && !status_clr);

    // read image, reserved and uncovered bits held at zero
    wire [31:0] bridge_img = {4'h0, tmo_serr_en_r, tmo_status_r, tmo_sel_r, 1'b0, 23'h0};
    wire [31:0] chip_img = {26'h0, live_ins_r, sec_pf_dis_r, 2'h0, mw_disc_ctl_r, 1'b0};
    assign rdata_nxt = hit_bridge ? bridge_img : (hit_chip ? chip_img : 32'h0);

    // writable fields, updated only through selected lanes
    always_ff @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            tmo_sel_r <= {2{btcc_pkg::RST_TMO_SEL}};
            tmo_serr_en_r <= btcc_pkg::RST_TMO_SERR_EN;
            mw_disc_ctl_r <= btcc_pkg::RST_MW_DISC_CTL;
            sec_pf_dis_r <= btcc_pkg::RST_SEC_PF_DIS;
            live_ins_r <= btcc_pkg::RST_LIVE_INS;
        end
        else
        begin
            if (wr_upper)
            begin
                tmo_sel_r <= CFG_WDATA[btcc_pkg::SEC_TMO_SEL_BIT:btcc_pkg::PRI_TMO_SEL_BIT];
                tmo_serr_en_r <= CFG_WDATA[btcc_pkg::TMO_SERR_EN_BIT];
            end
            if (wr_chip)
            begin
                mw_disc_ctl_r <= CFG_WDATA[btcc_pkg::MW_DISC_CTL_BIT];
                sec_pf_dis_r <= CFG_WDATA[btcc_pkg::SEC_PF_DIS_BIT];
                live_ins_r <= CFG_WDATA[btcc_pkg::LIVE_INS_BIT];
            end
        end
    end

    // status flag and read return
    always_ff @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            tmo_status_r <= btcc_pkg::RST_TMO_STATUS;
            rdata_r <= 32'h0;
            rvalid_r <= 1'b0;
        end
        else
        begin
            tmo_status_r <= tmo_status_nxt;
            rvalid_r <= CFG_RD;
            if (CFG_RD)
            begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    assign CFG_RDATA = rdata_r;
    assign CFG_RVALID = rvalid_r;
    assign SEC_FAST_B2B_EN = 1'b0;

    // ****************************************************************
    // delayed transaction master time-out, one per bus
    // ****************************************************************

    logic [btcc_pkg::TMO_CNT_W-1:0] cnt_r [2];
    logic seen_r [2];
    logic discard_r [2];
    wire [btcc_pkg::TMO_CNT_W-1:0] long_m1 = btcc_pkg::TMO_CNT_W'(TMO_LONG - 1);
    wire [btcc_pkg::TMO_CNT_W-1:0] short_m1 = btcc_pkg::TMO_CNT_W'(TMO_SHORT - 1);

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++)
        begin : g_tmo
            wire [btcc_pkg::TMO_CNT_W-1:0] lim_m1 = tmo_sel_r[ch] ? short_m1 : long_m1;
            wire run = DT_HEAD[ch] && !seen_r[ch] && !DT_REPEAT[ch];
            // at or past the limit, so a shortened limit mid-count expires at once
            assign expire[ch] = run && (cnt_r[ch] >= lim_m1);
            wire [btcc_pkg::TMO_CNT_W-1:0] cnt_nxt =
                (run && !expire[ch]) ? cnt_r[ch] + 1'b1 : '0;
            wire seen_nxt = DT_HEAD[ch] && !expire[ch] && (seen_r[ch] || DT_REPEAT[ch]);

            // counter runs while the unrepeated completion heads the queue
            always_ff @(posedge MCLK or negedge ARST_N)
            begin
                if (!ARST_N)
                begin
                    cnt_r[ch] <= '0;
                    seen_r[ch] <= 1'b0;
                    discard_r[ch] <= 1'b0;
                end
                else
                begin
                    cnt_r[ch] <= cnt_nxt;
                    seen_r[ch] <= seen_nxt;
                    discard_r[ch] <= expire[ch];
                end
            end
        end
    endgenerate

    assign DT_DISCARD = {discard_r[1], discard_r[0]};

    // ****************************************************************
    // system error on time-out discard
    // ****************************************************************

    logic serr_r;

    // one-cycle low drive of the open-drain serr pin
    always_ff @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            serr_r <= 1'b0;
        end
        else
        begin
            serr_r <= (|expire) && tmo_serr_en_r && CMD_SERR_EN;
        end
    end

    assign PRIMARY_SYSTEM_ERROR_N_O = 1'b0;
    assign PRIMARY_SYSTEM_ERROR_N_OE = serr_r;

    // ****************************************************************
    // memory write disconnect and upstream prefetch policy
    // ****************************************************************

    wire [9:0] cl_mask = CACHE_LINE_DW[7:0] == 8'h00 ? 10'h000
        : {2'h0, CACHE_LINE_DW - 8'h01};
    wire page_edge = MW_NEXT_ADDR[btcc_pkg::PAGE_ADDR_W-1:0] == 10'h000;
    wire line_edge = (CACHE_LINE_DW != 8'h00) && ((MW_NEXT_ADDR & cl_mask) == 10'h000);
    assign MW_DISCONNECT = MW_QUEUE_FULL || page_edge || (mw_disc_ctl_r && line_edge);

    wire is_mrd = US_RD_CMD == btcc_pkg::CMD_MEM_READ;
    wire is_mrd_bulk = (US_RD_CMD == btcc_pkg::CMD_MEM_READ_MULT)
        || (US_RD_CMD == btcc_pkg::CMD_MEM_READ_LINE);
    assign US_PREFETCH = is_mrd_bulk || (is_mrd && !sec_pf_dis_r);
    assign US_FWD_BE = is_mrd && sec_pf_dis_r;
    assign US_DISC_FIRST = is_mrd && sec_pf_dis_r;

    // ****************************************************************
    // live insertion masking of forwarding enables
    // ****************************************************************

    logic gpio_s1_r;
    logic gpio_s2_r;

    // two-flop synchroniser for the external pin
    always_ff @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            gpio_s1_r <= 1'b0;
            gpio_s2_r <= 1'b0;
        end
        else
        begin
            gpio_s1_r <= GPIO3_IN;
            gpio_s2_r <= gpio_s1_r;
        end
    end

    wire force_off = live_ins_r && GPIO3_INPUT_ONLY && gpio_s2_r;
    assign IO_EN_EFF = CMD_IO_EN && !force_off;
    assign MEM_EN_EFF = CMD_MEM_EN && !force_off;
    assign MASTER_EN_EFF = CMD_MASTER_EN && !force_off;
    assign ACCEPT_BLOCK = force_off;

    // ****************************************************************
    // assertions
    // ****************************************************************

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!ARST_N);

    fbb_zero_a: assert property (!SEC_FAST_B2B_EN && !CFG_RDATA[btcc_pkg::FBB_EN_BIT])
        else $error("fast back-to-back visible");
    pri_expiry_a: assert property (DT_DISCARD[0] |->
        $past(cnt_r[0]) >= (tmo_sel_r[0] ? short_m1 : long_m1) || $past(wr_upper))
        else $error("primary discard at wrong count");
    sec_expiry_a: assert property (DT_DISCARD[1] |-> $past(DT_HEAD[1]) && !$past(seen_r[1]))
        else $error("secondary discard without pending head");
    cnt_limit_a: assert property (cnt_r[0] <= long_m1 && cnt_r[1] <= long_m1)
        else $error("time-out counter beyond limit");
    status_set_a: assert property (|DT_DISCARD |-> tmo_status_r)
        else $error("status not set by discard");
    status_clr_a: assert property (status_clr && !(|expire) |=> !tmo_status_r)
        else $error("status not cleared by write one");
    serr_gate_a: assert property (PRIMARY_SYSTEM_ERROR_N_OE |->
        $past(|expire) && $past(tmo_serr_en_r) && $past(CMD_SERR_EN))
        else $error("serr driven without enables");
    rsvd_zero_a: assert property ((CFG_RDATA & btcc_pkg::RSVD_MASK) == 32'h0)
        else $error("reserved bit read nonzero");
    lane_hold_a: assert property (CFG_WR && PRIMARY_CMD_BYTE_ENABLE_N[0] |=>
        $stable({live_ins_r, sec_pf_dis_r, mw_disc_ctl_r}))
        else $error("unselected chip byte written");
    line_disc_a: assert property (mw_disc_ctl_r && line_edge |-> MW_DISCONNECT)
        else $error("no disconnect at cache line");
    pf_on_a: assert property (!sec_pf_dis_r && is_mrd |-> US_PREFETCH && !US_FWD_BE)
        else $error("prefetch policy wrong when enabled");
    pf_off_a: assert property (sec_pf_dis_r && is_mrd |-> !US_PREFETCH && US_DISC_FIRST)
        else $error("prefetch policy wrong when disabled");
    live_mask_a: assert property (live_ins_r && GPIO3_INPUT_ONLY && $past(GPIO3_IN, 2)
        && $past(live_ins_r) |-> !IO_EN_EFF && !MEM_EN_EFF && !MASTER_EN_EFF)
        else $error("live insertion mask failed");
    repeat_clr_a: assert property (DT_REPEAT[0] |=> cnt_r[0] == '0 && !DT_DISCARD[0])
        else $error("repeat did not stop counter");

endmodule : btcc_top
`default_nettype wire

// [dv/btcc_init_model.sv]
`default_nettype none
// ****************************************************************
// delayed transaction initiator standing on either bus
// ****************************************************************
module btcc_init_model (
    input wire logic mclk, // pci clock
    input wire logic [1:0] dt_discard, // discard pulses from the bridge
    output logic [1:0] dt_head, // completion at head of queue
    output logic [1:0] dt_repeat // initiator repeats its request
);
    // idle: no completion queued, no repeat
    initial
    begin
        dt_head = 2'b00;
        dt_repeat = 2'b00;
    end
    // hold a completion at the head, repeat once at rep_at, report the discard cycle
    task automatic await_done(input int bus, input int rep_at, input int limit,
                              output int waited);
        waited = -1;
        @(posedge mclk);
        dt_head[bus] <= 1'b1;
        for (int i = 1; i <= limit && waited < 0; i++)
        begin
            @(posedge mclk);
            dt_repeat[bus] <= (i == rep_at);
            #1;
            if (dt_discard[bus] === 1'b1)
                waited = i;
        end
        @(posedge mclk);
        dt_head[bus] <= 1'b0;
        dt_repeat[bus] <= 1'b0;
    endtask : await_done
endmodule : btcc_init_model
`default_nettype wire

// [dv/tb_top.sv]
`default_nettype none
// ****************************************************************
// bench for the time-out and chip-control bank
// ****************************************************************
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned LONG_N = 16;
    localparam int unsigned SHORT_N = 4;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic wr = 1'b0, rd = 1'b0, rvalid, serr_o, serr_oe, fbb, mw_full = 1'b0, mw_disc;
    logic [7:0] addr = 8'h00, cl_dw = 8'h08;
    logic [3:0] be_n = 4'hF, rd_cmd = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic serr_en = 1'b1, io_en = 1'b1, mem_en = 1'b1, mst_en = 1'b1;
    logic [1:0] head, rep, disc;
    logic [9:0] mw_addr = 10'h005;
    logic pf, fwd, dfirst, gpio = 1'b0, gpio_in_only = 1'b1, io_eff, mem_eff, mst_eff, blk;
    int fail_count = 0, n_checks = 0, oe_count = 0, oe0, w;
    logic [3:0] cmds [4] = '{4'h6, 4'hC, 4'hE, 4'h7};

    always #2.5 mclk = ~mclk;
    // count serr pulses driven on the primary pin, sampled mid-cycle
    always @(negedge mclk)
        if (serr_oe === 1'b1)
            oe_count++;

    btcc_top #(.TMO_LONG(LONG_N), .TMO_SHORT(SHORT_N)) dut_u (
        .MCLK(mclk), .ARST_N(arst_n), .CFG_WR(wr), .CFG_RD(rd), .CFG_ADDR(addr),
        .PRIMARY_CMD_BYTE_ENABLE_N(be_n), .CFG_WDATA(wdata), .CFG_RDATA(rdata),
        .CFG_RVALID(rvalid), .CMD_SERR_EN(serr_en), .CMD_IO_EN(io_en),
        .CMD_MEM_EN(mem_en), .CMD_MASTER_EN(mst_en), .DT_HEAD(head), .DT_REPEAT(rep),
        .DT_DISCARD(disc), .PRIMARY_SYSTEM_ERROR_N_O(serr_o),
        .PRIMARY_SYSTEM_ERROR_N_OE(serr_oe), .SEC_FAST_B2B_EN(fbb),
        .MW_QUEUE_FULL(mw_full), .MW_NEXT_ADDR(mw_addr), .CACHE_LINE_DW(cl_dw),
        .MW_DISCONNECT(mw_disc), .US_RD_CMD(rd_cmd), .US_PREFETCH(pf), .US_FWD_BE(fwd),
        .US_DISC_FIRST(dfirst), .GPIO3_IN(gpio), .GPIO3_INPUT_ONLY(gpio_in_only),
        .IO_EN_EFF(io_eff), .MEM_EN_EFF(mem_eff), .MASTER_EN_EFF(mst_eff),
        .ACCEPT_BLOCK(blk));

    btcc_init_model pm_u (.mclk(mclk), .dt_discard(disc), .dt_head(head), .dt_repeat(rep));

    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // verdict and end of run
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    // one config write data phase
    task automatic cfg_wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] v);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        be_n <= b;
        wdata <= v;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : cfg_wr
    // one config read, data taken with the valid pulse
    task automatic cfg_rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1 chk({31'h0, rvalid}, 32'h1);
        v = rdata;
    endtask : cfg_rd
    // drive write disconnect inputs and compare
    task automatic mw(input logic full, input logic [9:0] a, input logic exp);
        @(posedge mclk);
        mw_full <= full;
        mw_addr <= a;
        #1 chk({31'h0, mw_disc}, {31'h0, exp});
    endtask : mw

    // watchdog against a hang
    initial
    begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        conclude();
    end

    // main sequence
    initial
    begin
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        cfg_rd(8'h3C, d); chk(d, 32'h0);
        cfg_rd(8'h40, d); chk(d, 32'h0);
        cfg_rd(8'h80, d); chk(d, 32'h0);
        chk({31'h0, fbb}, 32'h0);
        $display("test reset values done");
        cfg_wr(8'h3C, 4'h0, 32'hFFFF_FFFF); cfg_rd(8'h3C, d); chk(d, 32'h0B00_0000);
        cfg_wr(8'h3C, 4'h8, 32'h0); cfg_rd(8'h3C, d); chk(d, 32'h0B00_0000);
        cfg_wr(8'h40, 4'hE, 32'hFFFF_FFFF); cfg_rd(8'h40, d); chk(d, 32'h32);
        cfg_wr(8'h40, 4'h1, 32'h0); cfg_rd(8'h40, d); chk(d, 32'h32);
        $display("test byte lanes done");
        oe0 = oe_count;
        pm_u.await_done(0, 0, 40, w); chk(w, SHORT_N);
        chk(oe_count - oe0, 1);
        chk({31'h0, serr_o}, 32'h0);
        cfg_rd(8'h3C, d); chk(d, 32'h0F00_0000);
        cfg_wr(8'h3C, 4'h7, 32'h0B00_0000); cfg_rd(8'h3C, d); chk(d, 32'h0F00_0000);
        cfg_wr(8'h3C, 4'h7, 32'h0F00_0000); cfg_rd(8'h3C, d); chk(d, 32'h0B00_0000);
        cfg_wr(8'h3C, 4'h7, 32'h0100_0000);
        oe0 = oe_count;
        pm_u.await_done(1, 0, 40, w); chk(w, LONG_N);
        chk(oe_count - oe0, 0);
        cfg_rd(8'h3C, d); chk(d, 32'h0500_0000);
        pm_u.await_done(0, 2, 40, w); chk(w, 32'hFFFF_FFFF);
        pm_u.await_done(0, 0, 40, w); chk(w, SHORT_N);
        $display("test time-out done");
        mw(1'b0, 10'h008, 1'b1);
        mw(1'b0, 10'h005, 1'b0);
        mw(1'b0, 10'h000, 1'b1);
        mw(1'b1, 10'h005, 1'b1);
        cfg_wr(8'h40, 4'hE, 32'h30);
        mw(1'b0, 10'h008, 1'b0);
        $display("test write disconnect done");
        for (int p = 1; p >= 0; p--)
        begin
            for (int k = 0; k < 4; k++)
            begin
                @(posedge mclk);
                rd_cmd <= cmds[k];
                #1 chk({pf, fwd, dfirst}, (k == 1 || k == 2 || (k == 0 && p == 0)) ? 3 'h4
                    : (k == 0 ? 3'h3 : 3'h0));
            end
            cfg_wr(8'h40, 4'hE, 32'h20);
        end
        $display("test upstream reads done");
        gpio <= 1'b1;
        repeat (3) @(posedge mclk);
        #1 chk({io_eff, mem_eff, mst_eff, blk}, 4'h1);
        @(posedge mclk);
        gpio_in_only <= 1'b0;
        #1 chk({io_eff, mem_eff, mst_eff, blk}, 4'hE);
        @(posedge mclk);
        gpio_in_only <= 1'b1;
        cfg_wr(8'h40, 4'hE, 32'h0);
        #1 chk({io_eff, mem_eff, mst_eff, blk}, 4'hE);
        $display("test live insertion done");
        conclude();
    end
endmodule : tb_top
`default_nettype wire
